/* File: hw/kws_defs.vh */
`ifndef KWS_DEFS_VH
`define KWS_DEFS_VH

// Register indices; the byte address is four times the index
`define KWS_IDX_CTRL 8'h30
`define KWS_IDX_ENABLE 8'h31
`define KWS_IDX_STATUS 8'h32
`define KWS_ADDR_WIDTH 12

// Key wake enable field
`define KWS_EN_MSB 7
`define KWS_EN_LSB 4
`define KWS_EN_RESET 4'h0

// Control register fields
`define KWS_CTRL_RELEASE_METHOD_SELECT_BIT 0
`define KWS_CTRL_HALT_BIT 1
`define KWS_CTRL_RESET 1'b0

// Status register fields
`define KWS_ST_HALTED_BIT 0
`define KWS_ST_WARMUP_BIT 1
`define KWS_ST_KEY_CAUSE_BIT 2
`define KWS_ST_PIN_CAUSE_BIT 3
`define KWS_ST_KEYS_LSB 4
`define KWS_ST_RELPIN_BIT 8

// Timing
`define KWS_CLK_MHZ 40
`define KWS_CLK_PER_INSTR 4
`define KWS_IGNORE_INSTR 3
`define KWS_IGNORE_CYC (`KWS_IGNORE_INSTR * `KWS_CLK_PER_INSTR)
`define KWS_WARMUP_US 2
`define KWS_WARMUP_CYC (`KWS_WARMUP_US * `KWS_CLK_MHZ)
`define KWS_CNT_WIDTH 16

`endif

/* File: hw/kws_key_wakeup.v */
`timescale 1ns/1ps
`include "kws_defs.vh"

// Function
// - Wake enable bits 7 to 4 of the key wake enable register gate each key pin independently, 1 enables.
// - After reset the four wake enable bits are zero and the low four bits carry nothing.
// - A rising or falling edge on any enabled key pin releases the device from halt.
// - The release signal is the OR of the dedicated release pin and the combined key edges.
// - The dedicated pin releases on a high level in level mode and a rising edge in edge mode, keys inhibited.
// - Key pin wakeup works only in level release mode.
// - Any release during the first three instruction cycles after halt entry is ignored.
// - After release the oscillator warm-up completes before execution resumes.
module kws_key_wakeup
#(
  parameter WARMUP_CYC = `KWS_WARMUP_CYC
)
(
  ref_clk,
  resetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  halt_req,
  release_pin,
  key_wake_pin_a,
  key_wake_pin_b,
  key_wake_pin_c,
  key_wake_pin_d,
  halt_release,
  osc_enable,
  core_run
);
  input wire ref_clk;
  input wire resetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [`KWS_ADDR_WIDTH-1:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire halt_req;
  input wire release_pin;
  input wire key_wake_pin_a;
  input wire key_wake_pin_b;
  input wire key_wake_pin_c;
  input wire key_wake_pin_d;
  output wire halt_release;
  output reg osc_enable;
  output reg core_run;

  localparam ST_RUN = 2'b00;
  localparam ST_IGNORE = 2'b01;
  localparam ST_HALT = 2'b10;
  localparam ST_WARM = 2'b11;

  localparam integer IGNORE_LAST_I = `KWS_IGNORE_CYC - 1;
  localparam integer WARM_LAST_I = WARMUP_CYC - 1;
  // Cut to the counter width on purpose; both counts fit with room to spare
  localparam [`KWS_CNT_WIDTH-1:0] IGNORE_LAST = IGNORE_LAST_I[`KWS_CNT_WIDTH-1:0];
  localparam [`KWS_CNT_WIDTH-1:0] WARM_LAST = WARM_LAST_I[`KWS_CNT_WIDTH-1:0];

  function hit;
    input [`KWS_ADDR_WIDTH-1:0] addr;
    input [7:0] idx;
    begin
      hit = (addr == {idx, 2'b00});
    end
  endfunction

  reg [3:0] wake_en_q;
  reg release_method_select_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`KWS_CNT_WIDTH-1:0] cnt_q;
  reg [`KWS_CNT_WIDTH-1:0] cnt_d;
  reg key_cause_q;
  reg pin_cause_q;
  reg sw_halt_q;
  reg [31:0] ctrl_word;
  reg [31:0] status_word;
  reg [31:0] rd_data_d;

  wire [4:0] lvl;
  wire [4:0] rise;
  wire [4:0] fall;
  wire [3:0] key_edge;
  wire key_release;
  wire pin_release;
  wire acc;
  wire map_hit;
  wire wr;
  wire wr_enable;
  wire wr_ctrl;
  wire rd_setup;
  wire halt_entry;
  wire release_seen;

  // Pins come from outside the clock domain; edge detection runs on synced levels
  kws_pin_sync u_sync
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pins({release_pin, key_wake_pin_d, key_wake_pin_c, key_wake_pin_b, key_wake_pin_a}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // Both edges count; each pin gated by its own enable
  assign key_edge = (rise[3:0] | fall[3:0]) & wake_en_q;
  // Keys are inhibited in edge release mode
  assign key_release = release_method_select_q & (|key_edge);
  assign pin_release = release_method_select_q ? lvl[4] : rise[4];
  assign halt_release = pin_release | key_release;

  assign acc = psel & penable;
  assign map_hit = hit(paddr, `KWS_IDX_CTRL) | hit(paddr, `KWS_IDX_ENABLE) | hit(paddr, `KWS_IDX_STATUS);
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  assign pslverr = acc & ~map_hit;

  assign wr_enable = wr & hit(paddr, `KWS_IDX_ENABLE);
  assign wr_ctrl = wr & hit(paddr, `KWS_IDX_CTRL);
  // Read data is captured in setup so it stands through the access phase
  assign rd_setup = psel & ~penable & ~pwrite;
  assign halt_entry = (state_q == ST_RUN) & (state_d == ST_IGNORE);
  assign release_seen = (state_q == ST_HALT) & halt_release;

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_en_q <= `KWS_EN_RESET;
    end
    else if (wr_enable)
    begin
      wake_en_q <= pwdata[`KWS_EN_MSB:`KWS_EN_LSB];
    end
  end

  // The halt bit is a one-clock strobe and never reads back
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      release_method_select_q <= `KWS_CTRL_RESET;
      sw_halt_q <= 1'b0;
    end
    else
    begin
      sw_halt_q <= wr_ctrl & pwdata[`KWS_CTRL_HALT_BIT];
      if (wr_ctrl)
      begin
        release_method_select_q <= pwdata[`KWS_CTRL_RELEASE_METHOD_SELECT_BIT];
      end
    end
  end

  always @*
  begin
    ctrl_word = 32'h00000000;
    ctrl_word[`KWS_CTRL_RELEASE_METHOD_SELECT_BIT] = release_method_select_q;
  end

  // Key and pin levels are the synced copies, two clocks behind the pins
  always @*
  begin
    status_word = 32'h00000000;
    status_word[`KWS_ST_HALTED_BIT] = ~osc_enable;
    status_word[`KWS_ST_WARMUP_BIT] = (state_q == ST_WARM);
    status_word[`KWS_ST_KEY_CAUSE_BIT] = key_cause_q;
    status_word[`KWS_ST_PIN_CAUSE_BIT] = pin_cause_q;
    status_word[`KWS_ST_KEYS_LSB+3:`KWS_ST_KEYS_LSB] = lvl[3:0];
    status_word[`KWS_ST_RELPIN_BIT] = lvl[4];
  end

  // Enable register is write-only and reads zero, like any unmapped offset
  always @*
  begin
    rd_data_d = 32'h00000000;
    if (hit(paddr, `KWS_IDX_CTRL))
    begin
      rd_data_d = ctrl_word;
    end
    else if (hit(paddr, `KWS_IDX_STATUS))
    begin
      rd_data_d = status_word;
    end
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (rd_setup)
    begin
      prdata <= rd_data_d;
    end
  end

  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_RUN:
      begin
        if (halt_req || sw_halt_q)
        begin
          state_d = ST_IGNORE;
          cnt_d = {`KWS_CNT_WIDTH{1'b0}};
        end
      end
      ST_IGNORE:
      begin
        // Release is not looked at during this window
        if (cnt_q == IGNORE_LAST)
        begin
          state_d = ST_HALT;
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_HALT:
      begin
        if (halt_release)
        begin
          state_d = ST_WARM;
          cnt_d = {`KWS_CNT_WIDTH{1'b0}};
        end
      end
      ST_WARM:
      begin
        if (cnt_q == WARM_LAST)
        begin
          state_d = ST_RUN;
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_RUN;
      cnt_q <= {`KWS_CNT_WIDTH{1'b0}};
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Oscillator stops in halt; core resumes only after warm-up
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_enable <= 1'b1;
      core_run <= 1'b1;
    end
    else
    begin
      osc_enable <= (state_d != ST_HALT);
      core_run <= (state_d == ST_RUN);
    end
  end

  // Causes clear on halt entry so a read after wake shows only the last release
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      key_cause_q <= 1'b0;
      pin_cause_q <= 1'b0;
    end
    else if (halt_entry)
    begin
      key_cause_q <= 1'b0;
      pin_cause_q <= 1'b0;
    end
    else if (release_seen)
    begin
      key_cause_q <= key_release;
      pin_cause_q <= pin_release;
    end
  end
endmodule // kws_key_wakeup

/* File: hw/kws_pin_sync.v */
`timescale 1ns/1ps
`include "kws_defs.vh"

module kws_pin_sync
(
  ref_clk,
  resetn,
  pins,
  level,
  rise,
  fall
);
  input wire ref_clk;
  input wire resetn;
  input wire [4:0] pins;
  output wire [4:0] level;
  output wire [4:0] rise;
  output wire [4:0] fall;

  reg [4:0] meta_q;
  reg [4:0] sync_q;
  reg [4:0] prev_q;

  // The first stage feeds only the second one
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
      prev_q <= 5'h00;
    end
    else
    begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // kws_pin_sync

/* File: tb/kws_checker.sv */
`timescale 1ns/1ps
module kws_checker #(parameter WARMUP_CYC = 80)
(
  input wire ref_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire halt_req,
  input wire release_pin,
  input wire key_wake_pin_a,
  input wire key_wake_pin_b,
  input wire key_wake_pin_c,
  input wire key_wake_pin_d,
  input wire halt_release,
  input wire osc_enable,
  input wire core_run
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  reg [15:0] w_q;
  always @(posedge ref_clk or negedge resetn)
    if (!resetn)
      w_q <= 16'h0;
    else
      w_q <= osc_enable && !core_run ? w_q + 16'h1 : 16'h0;
  property p_ign; halt_req |=> osc_enable [*8] ##[1:8] !osc_enable; endproperty
  a_ign: assert property (p_ign) else $error("ignore window");
  property p_warm; $rose(core_run) |-> w_q >= WARMUP_CYC - 1 && w_q <= WARMUP_CYC + 2; endproperty
  a_warm: assert property (p_warm) else $error("warm-up");
  property p_pin; !osc_enable && $rose(release_pin) |-> ##[1:4] halt_release; endproperty
  a_pin: assert property (p_pin) else $error("pin release");
  property p_sync; !osc_enable && $rose(release_pin) && !halt_release |=> !halt_release; endproperty
  a_sync: assert property (p_sync) else $error("unsynced");
  property p_wake; !osc_enable && halt_release |=> osc_enable; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_run; !osc_enable |-> !core_run; endproperty
  a_run: assert property (p_run) else $error("run in halt");
  property p_wo; psel && !penable && !pwrite && paddr == 12'hc4 |=> prdata == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("enable readable");
  property p_err; psel && penable |-> pready && pslverr == !(paddr inside {12'hc0, 12'hc4, 12'hc8}); endproperty
  a_err: assert property (p_err) else $error("bus response");
  c_wake: cover property ($rose(core_run));
  c_pin: cover property (!osc_enable && release_pin);
  c_err: cover property (pslverr);
endmodule // kws_checker

bind kws_key_wakeup kws_checker #(.WARMUP_CYC(WARMUP_CYC)) u_chk (.*);

/* File: tb/kws_key_model.sv */
`timescale 1ns/1ps
module kws_key_model
(
  input wire ref_clk,
  output logic [3:0] keys,
  output logic release_pin
);
  initial
  begin
    keys = 4'h0;
    release_pin = 1'b0;
  end
  // Keys move one at a time, for wake edges and for edges that must not wake
  task flip(input int i);
    @(posedge ref_clk) keys[i] <= ~keys[i];
  endtask
  // Long enough for the synchroniser in either mode
  task press(input int n);
    @(posedge ref_clk) release_pin <= 1'b1;
    repeat (n) @(posedge ref_clk);
    release_pin <= 1'b0;
  endtask
endmodule // kws_key_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "kws_defs.vh"
module testbench;
  logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, halt_req = 1'b0, se;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, halt_release, osc_enable, core_run, release_pin;
  wire [3:0] keys;
  wire key_wake_pin_a = keys[0], key_wake_pin_b = keys[1], key_wake_pin_c = keys[2], key_wake_pin_d = keys[3];
  int error_cnt = 0, total_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  kws_key_model u_key (.*);
  // Short warm-up keeps the run brief
  kws_key_wakeup #(.WARMUP_CYC(4)) u_dut (.*);
  task final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'h0, a, 2'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (int n = 0; n < 9; n++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
      if (n == 8)
      begin
        error_cnt++;
        final_report;
      end
    end
    {rd, se} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task woke(input logic e);
    repeat (40)
      if (core_run !== 1'b1)
        @(posedge ref_clk);
    chk("core_run", e, core_run);
    if (e && core_run !== 1'b1)
      final_report;
  endtask
  // Key k moves inside the ignore window; 4 means none
  task halt(input int k);
    @(posedge ref_clk) halt_req <= 1'b1;
    @(posedge ref_clk) halt_req <= 1'b0;
    if (k < 4)
      u_key.flip(k);
    repeat (16) @(posedge ref_clk);
  endtask
  task s_reset;
    apb(1'b0, `KWS_IDX_ENABLE);
    chk("enable", 32'h0, rd);
    chk("pslverr", 32'h0, se);
    apb(1'b0, 8'h33);
    chk("pslverr", 32'h1, se);
    apb(1'b1, `KWS_IDX_CTRL, 32'h1);
    halt(4);
    for (int i = 0; i < 4; i++)
      u_key.flip(i);
    woke(1'b0);
    u_key.press(6);
    woke(1'b1);
  endtask
  task s_keys;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `KWS_IDX_ENABLE, 32'h10 << i);
      halt(4);
      u_key.flip((i + 1) % 4);
      woke(1'b0);
      u_key.flip(i);
      woke(1'b1);
      apb(1'b0, `KWS_IDX_STATUS);
      chk("cause", 32'h1, rd[3:2]);
    end
  endtask
  // Halt by the control strobe, released by the pin level
  task s_swhalt;
    apb(1'b1, `KWS_IDX_CTRL, 32'h3);
    repeat (16) @(posedge ref_clk);
    chk("osc_enable", 32'h0, osc_enable);
    apb(1'b0, `KWS_IDX_STATUS);
    chk("halted", 32'h1, rd[1:0]);
    u_key.press(6);
    woke(1'b1);
    apb(1'b0, `KWS_IDX_CTRL);
    chk("ctrl", 32'h1, rd);
  endtask
  task s_edge;
    apb(1'b1, `KWS_IDX_CTRL, 32'h0);
    apb(1'b1, `KWS_IDX_ENABLE, 32'hf0);
    halt(4);
    u_key.flip(2);
    woke(1'b0);
    u_key.press(6);
    woke(1'b1);
    apb(1'b0, `KWS_IDX_STATUS);
    chk("cause", 32'h2, rd[3:2]);
    apb(1'b1, `KWS_IDX_CTRL, 32'h1);
    halt(1);
    woke(1'b0);
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    s_reset;
    s_keys;
    s_swhalt;
    s_edge;
    final_report;
  end
endmodule // testbench
